/* rtl/sacp_pkg.sv */
package sacp_pkg;

    // Result width and pin indices on the synchroniser
    localparam int RESULT_BITS = 12;
    localparam int PIN_COUNT = 2;
    localparam int PIN_STROBE = 0;
    localparam int PIN_SCLK = 1;
    localparam int SYNC_STAGES = 3;

    // Conversion clock numbering within a frame
    localparam int COUNT_BITS = 5;
    localparam logic [4:0] CLK_START = 5'h01;
    localparam logic [4:0] CLK_LSB = 5'h0d;
    localparam logic [4:0] CLK_ARM_LAST = 5'h0c;
    localparam logic [4:0] CLK_LSB_FIRST_END = 5'h18;
    localparam logic [4:0] CLK_BITS_BASE = 5'h0d;

    // Reset values
    localparam logic [11:0] HELD_RESET = 12'h000;
    localparam logic [4:0] COUNT_RESET = 5'h00;

    // Pin timing limits, with worst-case cycle budgets for the data-valid and data-float limits only
    localparam int CLOCK_PERIOD_NS = 8;
    localparam int ACQUIRE_MIN_TIME_NS = 350;
    localparam int HOLD_DROOP_LIMIT_NS = 5000;
    localparam int DATA_VALID_MAX_NS = 50;
    localparam int DATA_HIZ_MAX_NS = 100;
    localparam int DATA_VALID_MAX_CYC = (DATA_VALID_MAX_NS / CLOCK_PERIOD_NS < 1) ? 1
                                        : DATA_VALID_MAX_NS / CLOCK_PERIOD_NS;
    localparam int DATA_HIZ_MAX_CYC = (DATA_HIZ_MAX_NS / CLOCK_PERIOD_NS < 1) ? 1
                                      : DATA_HIZ_MAX_NS / CLOCK_PERIOD_NS;

    // Frame states
    typedef enum logic [2:0]
    {
        ST_SAMPLE,
        ST_HOLD,
        ST_CONVERT,
        ST_LSB_FIRST,
        ST_POWER_DOWN
    } sacp_state_t;

endpackage : sacp_pkg

/* rtl/sacp_pin_if.sv */
interface sacp_pin_if;
    import sacp_pkg::*;

    logic [PIN_COUNT-1:0] level;
    logic [PIN_COUNT-1:0] rise;
    logic [PIN_COUNT-1:0] fall;

    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface : sacp_pin_if

/* rtl/sacp_pin_sync.sv */
module sacp_pin_sync
    import sacp_pkg::*;
(
    input wire logic i_clock, // System clock
    input wire logic i_reset_n, // Async reset, active low
    input wire logic [sacp_pkg::PIN_COUNT-1:0] i_pins, // Raw pins
    sacp_pin_if.src pins // Filtered levels and edges
);
    logic [PIN_COUNT-1:0] stage1;
    logic [PIN_COUNT-1:0] stage2;
    logic [PIN_COUNT-1:0] stage3;
    logic [PIN_COUNT-1:0] level;
    logic [PIN_COUNT-1:0] next_stage1;
    logic [PIN_COUNT-1:0] next_stage2;
    logic [PIN_COUNT-1:0] next_stage3;
    logic [PIN_COUNT-1:0] next_level;

    // Stage one feeds only stage two; a change counts once two and three agree
    always_comb
    begin
        next_stage1 = i_pins;
        next_stage2 = stage1;
        next_stage3 = stage2;
        next_level = level;
        for (int i = 0; i < PIN_COUNT; i++)
        begin
            if (stage2[i] == stage3[i])
            begin
                next_level[i] = stage3[i];
            end
        end
    end

    // Low at reset so a high strobe after release reads as a rising edge
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            level <= '0;
        end
        else
        begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
            stage3 <= next_stage3;
            level <= next_level;
        end
    end

    // Edges are one-cycle pulses aligned with the level update
    always_comb
    begin
        pins.level = level;
        pins.rise = next_level & ~level;
        pins.fall = ~next_level & level;
    end

endmodule : sacp_pin_sync

/* rtl/sacp_convert_strobe_port.sv */
module sacp_convert_strobe_port
    import sacp_pkg::*;
(
    input wire logic i_clock, // 125 MHz system clock
    input wire logic i_reset_n, // Async reset, active low
    input wire logic i_convert_strobe, // Convert strobe pin, async
    input wire logic i_convert_strobe_clock, // Conversion clock pin, async
    input wire logic [sacp_pkg::RESULT_BITS-1:0] i_sample_value, // Converter core code
    output logic o_data, // Serial data out
    output logic o_data_oe, // Serial data drive enable
    output logic o_hold, // Hold mode, high while held
    output logic o_power_down // Power-down mode
);
    sacp_pin_if pins ();

    sacp_state_t state;
    sacp_state_t next_state;
    logic [COUNT_BITS-1:0] count;
    logic [COUNT_BITS-1:0] next_count;
    logic [RESULT_BITS-1:0] held;
    logic [RESULT_BITS-1:0] next_held;
    logic arm_lsb;
    logic next_arm_lsb;
    logic pd_pending;
    logic next_pd_pending;
    logic data;
    logic next_data;
    logic data_oe;
    logic next_data_oe;
    logic hold;
    logic next_hold;
    logic power_down;
    logic next_power_down;
    logic strobe_fall;
    logic strobe_rise;
    logic strobe_level;
    logic sclk_fall;
    logic [COUNT_BITS-1:0] count_inc;
    logic [COUNT_BITS-1:0] msb_index;
    logic [COUNT_BITS-1:0] lsb_index;

    // Both pins cross into the system clock through three flops
    sacp_pin_sync u_sync
    (
        .i_clock (i_clock),
        .i_reset_n (i_reset_n),
        .i_pins ({i_convert_strobe_clock, i_convert_strobe}),
        .pins (pins)
    );

    // Edge and bit-index helpers
    always_comb
    begin
        strobe_fall = pins.fall[PIN_STROBE];
        strobe_rise = pins.rise[PIN_STROBE];
        strobe_level = pins.level[PIN_STROBE];
        sclk_fall = pins.fall[PIN_SCLK];
        count_inc = count + 5'h01;
        msb_index = CLK_BITS_BASE - count_inc;
        lsb_index = count_inc - CLK_BITS_BASE;
    end

    // Frame sequencing; a strobe edge outranks a clock edge in the same cycle
    always_comb
    begin
        next_state = state;
        next_count = count;
        next_held = held;
        next_arm_lsb = arm_lsb;
        next_pd_pending = pd_pending;
        next_data = data;
        next_data_oe = data_oe;
        next_hold = hold;
        next_power_down = power_down;
        case (state)
            ST_SAMPLE:
            begin
                next_data_oe = 1'b0;
                if (strobe_fall)
                begin
                    next_held = i_sample_value;
                    next_hold = 1'b1;
                    next_count = COUNT_RESET;
                    next_arm_lsb = 1'b0;
                    next_pd_pending = 1'b0;
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                // first clock is the first fall seen after the strobe fall
                if (strobe_rise)
                begin
                    next_hold = 1'b0;
                    next_state = ST_SAMPLE;
                end
                else if (sclk_fall)
                begin
                    next_count = CLK_START;
                    next_data = 1'b0;
                    next_data_oe = 1'b1;
                    next_state = ST_CONVERT;
                end
            end
            ST_CONVERT:
            begin
                if (strobe_rise || strobe_fall)
                begin
                    next_data_oe = 1'b0;
                    // rise up to clock 12 arms LSB-first
                    if (strobe_rise && count <= CLK_ARM_LAST)
                    begin
                        next_arm_lsb = 1'b1;
                    end
                    if (strobe_rise)
                    begin
                        next_pd_pending = 1'b0;
                        next_power_down = 1'b0;
                    end
                    // fall during clock 13 enters LSB-first
                    if (strobe_fall && count == CLK_LSB && arm_lsb)
                    begin
                        next_power_down = 1'b1;
                        next_state = ST_LSB_FIRST;
                    end
                end
                else if (sclk_fall)
                begin
                    if (count == CLK_LSB)
                    begin
                        next_data_oe = 1'b0;
                        next_hold = 1'b0;
                        next_state = pd_pending ? ST_POWER_DOWN : ST_SAMPLE;
                    end
                    else
                    begin
                        // MSB first from the held code
                        next_count = count_inc;
                        next_data = held[msb_index[3:0]];
                        next_data_oe = 1'b1;
                        // strobe still low at clock 13 start
                        if (count_inc == CLK_LSB && !strobe_level && !arm_lsb)
                        begin
                            next_pd_pending = 1'b1;
                            next_power_down = 1'b1;
                        end
                    end
                end
            end
            ST_LSB_FIRST:
            begin
                if (strobe_rise)
                begin
                    next_data_oe = 1'b0;
                    next_power_down = 1'b0;
                    next_hold = 1'b0;
                    next_state = ST_SAMPLE;
                end
                else if (sclk_fall)
                begin
                    if (count == CLK_LSB_FIRST_END)
                    begin
                        next_data_oe = 1'b0;
                        next_hold = 1'b0;
                        next_state = ST_POWER_DOWN;
                    end
                    else
                    begin
                        // resend D1 upward, same held code
                        next_count = count_inc;
                        next_data = held[lsb_index[3:0]];
                        next_data_oe = 1'b1;
                    end
                end
            end
            ST_POWER_DOWN:
            begin
                next_data_oe = 1'b0;
                next_power_down = 1'b1;
                // wake straight into a valid sampling phase
                if (strobe_rise)
                begin
                    next_power_down = 1'b0;
                    next_state = ST_SAMPLE;
                end
            end
            default:
            begin
                next_state = ST_POWER_DOWN;
            end
        endcase
    end

    // Starts powered down so the first strobe rise begins a clean acquisition
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state <= ST_POWER_DOWN;
            count <= COUNT_RESET;
            held <= HELD_RESET;
            arm_lsb <= 1'b0;
            pd_pending <= 1'b0;
            data <= 1'b0;
            data_oe <= 1'b0;
            hold <= 1'b0;
            power_down <= 1'b1;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
            held <= next_held;
            arm_lsb <= next_arm_lsb;
            pd_pending <= next_pd_pending;
            data <= next_data;
            data_oe <= next_data_oe;
            hold <= next_hold;
            power_down <= next_power_down;
        end
    end

    // held code goes out as plain binary
    always_comb
    begin
        o_data = data;
        o_data_oe = data_oe;
        o_hold = hold;
        o_power_down = power_down;
    end

endmodule : sacp_convert_strobe_port

/* dv/sacp_convert_strobe_port_monitor.sv */
module sacp_convert_strobe_port_monitor
    import sacp_pkg::*;
(
    input wire logic i_clock, // System clock
    input wire logic i_reset_n, // Async reset, active low
    input wire logic i_convert_strobe, // Strobe pin
    input wire logic i_convert_strobe_clock, // Conversion clock pin
    input wire logic [sacp_pkg::RESULT_BITS-1:0] i_sample_value, // Core code
    input wire logic o_data, // Serial data
    input wire logic o_data_oe, // Data drive enable
    input wire logic o_hold, // Hold mode
    input wire logic o_power_down // Power-down mode
);
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_q;
    logic hold_q;
    logic [4:0] since_fall;
    logic [4:0] next_since_fall;
    logic first_pending;
    logic next_first_pending;

    // Age of last clock fall, saturating so long idle gaps stay bounded
    always_comb
    begin
        next_since_fall = (since_fall == 5'h1f) ? since_fall : since_fall + 5'h01;
        if (clk_q && !i_convert_strobe_clock)
            next_since_fall = 5'h00;
        next_first_pending = first_pending;
        if (o_hold && !hold_q)
            next_first_pending = 1'b1;
        else if (o_data_oe)
            next_first_pending = 1'b0;
    end

    // Helper registers
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            clk_q <= 1'b0;
            hold_q <= 1'b0;
            since_fall <= 5'h1f;
            first_pending <= 1'b0;
        end
        else
        begin
            clk_q <= i_convert_strobe_clock;
            hold_q <= o_hold;
            since_fall <= next_since_fall;
            first_pending <= next_first_pending;
        end
    end

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_reset_n);

    AST_HOLD_ON_FALL: assert property ($fell(i_convert_strobe) && !o_hold && !o_power_down |-> ##[1:6] o_hold)
        else $error("hold did not follow strobe fall");
    AST_HIZ_ON_STROBE: assert property ($changed(i_convert_strobe) |-> ##[1:12] !o_data_oe)
        else $error("data line not floated after strobe change");
    AST_START_LOW: assert property (first_pending && o_data_oe |-> !o_data)
        else $error("start bit not low");
    AST_START_BOUND: assert property ($rose(o_hold) |-> ##[1:640] (o_data_oe || !o_hold))
        else $error("data line never left high impedance");
    AST_BIT_TIMING: assert property (o_data_oe && ($changed(o_data) || $rose(o_data_oe)) |-> since_fall <= 5'h06)
        else $error("data bit changed away from a clock fall");
    AST_IDLE_HIZ: assert property (!o_hold |-> !o_data_oe)
        else $error("data driven outside a frame");
    AST_PD_ENTRY: assert property ($rose(o_power_down) |-> o_hold && !i_convert_strobe)
        else $error("power-down entered with strobe high");
    AST_PD_STAYS: assert property ((o_power_down && !i_convert_strobe) [*8] |=> o_power_down)
        else $error("power-down left while strobe low");
    AST_PD_EXIT: assert property ($rose(i_convert_strobe) && o_power_down |-> ##[1:6] !o_power_down)
        else $error("strobe rise did not wake the converter");
    AST_RESET_STATE: assert property ($rose(i_reset_n) |-> o_power_down && !o_data_oe && !o_hold)
        else $error("wrong state after reset");
endmodule : sacp_convert_strobe_port_monitor

bind sacp_convert_strobe_port sacp_convert_strobe_port_monitor u_sacp_convert_strobe_port_monitor (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_convert_strobe(i_convert_strobe), .i_convert_strobe_clock(i_convert_strobe_clock), .i_sample_value(i_sample_value),
    .o_data(o_data), .o_data_oe(o_data_oe), .o_hold(o_hold), .o_power_down(o_power_down));

/* dv/sacp_host_model.sv */
module sacp_host_model
    import sacp_pkg::*;
(
    input wire logic i_clock, // Time base for pin edges
    output logic o_convert_strobe, // Convert strobe pin
    output logic o_convert_strobe_clock, // Conversion clock pin
    input wire logic i_data, // Data line, pulled up
    output logic [sacp_pkg::RESULT_BITS-1:0] o_word, // Captured result
    output logic o_word_valid // Pulse per captured result
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        o_convert_strobe = 1'b1;
        o_convert_strobe_clock = 1'b0;
        o_word = '0;
        o_word_valid = 1'b0;
    end

    // Edges land 3 ns after a system edge, clear of the sampling race
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_clock);
        #3;
    endtask : wait_cyc

    task automatic publish(input logic [11:0] w);
        o_word = w;
        o_word_valid = 1'b1;
        wait_cyc(1);
        o_word_valid = 1'b0;
        // Gap so back-to-back results give two separate pulses
        wait_cyc(1);
    endtask : publish

    // Mode 0 normal, 1 power-down, 2 LSB-first, 3 abort in hold; gated clock, 128 ns period
    task automatic frame(input int mode, input int rise_at, input logic park_high);
        logic [11:0] msb;
        logic [11:0] lsb;
        int n;
        wait_cyc(48);
        o_convert_strobe_clock = 1'b1;
        // strobe falls well after the last clock edge
        wait_cyc(4);
        o_convert_strobe = 1'b0;
        // first clock far inside the droop limit
        wait_cyc(12);
        // Abort gives up before any clock, so no result comes back
        if (mode == 3)
        begin
            o_convert_strobe = 1'b1;
            wait_cyc(12);
            return;
        end
        // 16 clocks, or 25 for retransmission
        n = (mode == 2) ? 25 : 16;
        for (int k = 1; k <= n; k++)
        begin
            o_convert_strobe_clock = 1'b0;
            wait_cyc(8);
            if (k >= 2 && k <= 13) msb = {msb[10:0], i_data};
            if (k >= 13 && k <= 24) lsb = {i_data, lsb[11:1]};
            o_convert_strobe_clock = 1'b1;
            // rise before clock 12 ends, fall inside clock 13
            if (mode != 1 && k == rise_at) o_convert_strobe = 1'b1;
            if (mode == 2 && k == 13) o_convert_strobe = 1'b0;
            wait_cyc(8);
        end
        o_convert_strobe = 1'b1;
        o_convert_strobe_clock = park_high;
        publish(msb);
        if (mode == 2) publish(lsb);
    endtask : frame
endmodule : sacp_host_model

/* dv/sar_adc_serial_conversion_port_test.sv */
module sar_adc_serial_conversion_port_test;
    import sacp_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic i_clock;
    logic i_reset_n;
    logic [RESULT_BITS-1:0] sample_value;
    logic convert_strobe, convert_strobe_clock, data, data_oe, hold, power_down, word_valid;
    logic [RESULT_BITS-1:0] word;
    logic [RESULT_BITS-1:0] expect_q[$];
    tri1 data_line;
    int num_errors;
    int checks;
    int seed;
    int mode;

    // Undriven line floats to the pull-up level
    assign data_line = data_oe ? data : 1'bz;

    always #4 i_clock = ~i_clock;

    sacp_convert_strobe_port u_sacp_convert_strobe_port (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_convert_strobe(convert_strobe),
        .i_convert_strobe_clock(convert_strobe_clock), .i_sample_value(sample_value), .o_data(data), .o_data_oe(data_oe),
        .o_hold(hold), .o_power_down(power_down));

    sacp_host_model u_sacp_host_model (.i_clock(i_clock), .o_convert_strobe(convert_strobe),
        .o_convert_strobe_clock(convert_strobe_clock), .i_data(data_line), .o_word(word), .o_word_valid(word_valid));

    task automatic check_word(input string name, input logic [11:0] exp, input logic [11:0] got);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check_word

    task automatic finish_test;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test

    // Results matched in order against the driver's predictions
    always @(posedge word_valid)
    begin
        check_word("result", (expect_q.size() > 0) ? expect_q.pop_front() : 12'hxxx, word);
    end

    // Twelve frames take about 4500 cycles
    initial
    begin
        #200000;
        num_errors++;
        $display("CHECK FAILED watchdog expected done seen hang");
        finish_test();
    end

    initial
    begin
        i_clock = 1'b0;
        i_reset_n = 1'b0;
        sample_value = 12'h000;
        num_errors = 0;
        checks = 0;
        seed = 17439;
        repeat (6) @(posedge i_clock);
        #3;
        i_reset_n = 1'b1;
        for (int t = 0; t < 20 && power_down !== 1'b0; t++) @(posedge i_clock);
        check_word("wake", 12'h000, {11'h000, power_down});
        // Boundary codes first, then random; modes rotate so modes 0 and 2 each follow a power-down
        for (int i = 0; i < 12; i++)
        begin
            @(posedge i_clock);
            #3;
            sample_value = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : 12'($random(seed));
            mode = i % 3;
            expect_q.push_back(sample_value);
            if (mode == 2) expect_q.push_back(sample_value);
            fork
                u_sacp_host_model.frame(mode, 2 + (i % 11), i[0]);
                begin
                    // Core value moves after hold; result must not follow it
                    wait (hold === 1'b1);
                    @(posedge i_clock);
                    #3;
                    sample_value = ~sample_value;
                end
            join
        end
        // Strobe rise before any clock must abort and leave the line floating
        u_sacp_host_model.frame(3, 0, 1'b1);
        check_word("abort hold", 12'h000, {11'h000, hold});
        check_word("abort drive", 12'h000, {11'h000, data_oe});
        repeat (4) @(posedge i_clock);
        check_word("pending", 12'h000, 12'(expect_q.size()));
        finish_test();
    end
endmodule : sar_adc_serial_conversion_port_test
